// ===== rtl/stw_pkg.sv
// Package of register offsets, reset values and field positions for the system timers.
// Assumes an 8-bit special function register port with byte addresses.
package stw_pkg;
  localparam logic [7:0] ADDR_CONV_DIV   = 8'hF6;
  localparam logic [7:0] ADDR_SW_RESET   = 8'hF7;
  localparam logic [7:0] ADDR_IRQ_PRIO   = 8'hF8;
  localparam logic [7:0] ADDR_SEC_INT    = 8'hF9;
  localparam logic [7:0] ADDR_MS_INT     = 8'hFA;
  localparam logic [7:0] ADDR_MICROSECOND_DIVIDER_DIV   = 8'hFB;
  localparam logic [7:0] ADDR_MS_DIV_LO  = 8'hFC;
  localparam logic [7:0] ADDR_MS_DIV_HI  = 8'hFD;
  localparam logic [7:0] ADDR_HMS_DIV    = 8'hFE;
  localparam logic [7:0] ADDR_WDOG_CTRL  = 8'hFF;
  localparam logic [7:0] RST_CONV_DIV    = 8'h03;
  localparam logic [7:0] RST_IRQ_PRIO    = 8'hE0;
  localparam logic [7:0] RST_INTERVAL    = 8'h7F;
  localparam logic [7:0] RST_MICROSECOND_DIVIDER_DIV    = 8'h03;
  localparam logic [7:0] RST_MS_DIV_LO   = 8'h9F;
  localparam logic [7:0] RST_MS_DIV_HI   = 8'h0F;
  localparam logic [7:0] RST_HMS_DIV     = 8'h63;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] PRIO_FIXED_ONES = 8'hE0;
  localparam logic [7:0] PRIO_MASK       = 8'h1F;
  localparam logic [7:0] INTERVAL_MASK   = 8'h7F;
  localparam logic [7:0] MICROSECOND_DIVIDER_MASK       = 8'h1F;
  localparam logic [7:0] WDOG_CNT_MASK   = 8'h1F;
  localparam int         BIT_LOAD_NOW    = 7;
  localparam int         BIT_RESET_REQ   = 0;
  localparam int         BIT_WD_ARM      = 7;
  localparam int         BIT_WD_DISARM   = 6;
  localparam int         BIT_WD_RESTART  = 5;
  localparam int         MOD_DIV_W       = 6;
  localparam int         REG_COUNT       = 10;
endpackage : stw_pkg

// ===== rtl/stw_regmem.sv
// Small register store for the plain read/write divider and control registers.
// Assumes one write port and one registered read port, all on clk_in.
`timescale 1ns/100ps
module stw_regmem (
  // Clock, reset and enable
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Write port
  input  wire logic       wr_en_in,
  input  wire logic [3:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  // Read port
  input  wire logic [3:0] rd_idx_in,
  output logic      [7:0] rd_data_out
);
  logic [7:0] mem_r [stw_pkg::REG_COUNT];

  function automatic logic [7:0] reset_of(input int idx);
    unique case (idx)
      0:       reset_of = stw_pkg::RST_CONV_DIV;
      2:       reset_of = stw_pkg::RST_IRQ_PRIO;
      3, 4:    reset_of = stw_pkg::RST_INTERVAL;
      5:       reset_of = stw_pkg::RST_MICROSECOND_DIVIDER_DIV;
      6:       reset_of = stw_pkg::RST_MS_DIV_LO;
      7:       reset_of = stw_pkg::RST_MS_DIV_HI;
      8:       reset_of = stw_pkg::RST_HMS_DIV;
      default: reset_of = stw_pkg::RST_ZERO;
    endcase
  endfunction : reset_of

  genvar g;
  generate
    for (g = 0; g < stw_pkg::REG_COUNT; g++) begin : g_word
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          mem_r[g] <= reset_of(g);
        end else if (ce_in && wr_en_in && (wr_idx_in == 4'(g))) begin
          mem_r[g] <= wr_data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= stw_pkg::RST_ZERO;
    end else if (ce_in) begin
      rd_data_out <= (rd_idx_in < 4'(stw_pkg::REG_COUNT)) ? mem_r[rd_idx_in] : stw_pkg::RST_ZERO;
    end
  end
endmodule : stw_regmem

// ===== rtl/stw_timers.sv
// System timing dividers, millisecond and seconds interval timers and the watchdog.
// Assumes a special function register port on clk_in; read data is valid one cycle later.
//
// Operation
// R1 - converter clock divide by field plus one
// R2 - reset bit write one then zero resets
// R3 - seconds timer counts hundred millisecond ticks
// R4 - seconds register read clears seconds interrupt
// R5 - load timing bit reads zero, selects load
// R6 - millisecond timer interrupts per interval ticks
// R7 - millisecond register read clears its interrupt
// R8 - microsecond tick divides clock by field plus one
// R9 - millisecond tick from sixteen bit divider
// R10 - millisecond tick also times flash erase
// R11 - hundred millisecond tick divides millisecond tick
// R12 - arm bit one then zero enables watchdog
// R13 - disarm bit one then zero disables watchdog
// R14 - restart bit one then zero reloads watchdog
// R15 - watchdog expires after count plus one periods; the logic expires on hundred millisecond tick count plus two
// R16 - priority bits, upper three read one
// R17 - watchdog interrupt forwarded only when enabled
// R18 - power down bits stop watchdog, system timer
// R19 - sequence is set write then clearing write
// R20 - expiry interrupts if enabled, else resets
`timescale 1ns/100ps
module stw_timers (
  // Clock, reset and enable
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Special function register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // Controls held by other blocks
  input  wire logic       watchdog_irq_enable_in,
  input  wire logic       watchdog_power_down_in,
  input  wire logic       system_timer_power_down_in,
  input  wire logic [7:0] decimation_ratio_in,
  // Clocks and ticks
  output logic            conv_clk_tick_out,
  output logic            mod_clk_tick_out,
  output logic            data_rate_tick_out,
  output logic            microsecond_divider_tick_out,
  output logic            msec_tick_out,
  output logic            hms_tick_out,
  // Interrupts and resets
  output logic            ms_irq_out,
  output logic            sec_irq_out,
  output logic            watchdog_irq_out,
  output logic            system_reset_out,
  output logic [4:0]      irq_priority_out
);
  logic       wr_hit;
  logic       rd_hit;
  logic [3:0] idx;
  logic [7:0] conv_div;
  logic [7:0] microsecond_divider_div;
  logic [7:0] ms_lo;
  logic [7:0] ms_hi;
  logic [7:0] hms_div;
  logic [7:0] prio;
  logic [7:0] wd_ctrl;
  logic       wr_en_mem;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register decode and store.

  assign wr_hit = ce_in && sfr_wr_in && (sfr_addr_in >= stw_pkg::ADDR_CONV_DIV);
  assign rd_hit = ce_in && sfr_rd_in && (sfr_addr_in >= stw_pkg::ADDR_CONV_DIV);
  assign idx    = 4'(sfr_addr_in - stw_pkg::ADDR_CONV_DIV);

  // Control registers are shadowed outside the store so their fields can steer logic directly.
  logic [7:0] conv_div_r, microsecond_divider_div_r, ms_lo_r, ms_hi_r, hms_div_r, prio_r, wd_ctrl_r;
  logic [6:0] sec_load_r, ms_load_r;

  assign wr_en_mem = wr_hit;

  stw_regmem u_mem (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .wr_en_in    (wr_en_mem),
    .wr_idx_in   (idx),
    .wr_data_in  (sfr_wdata_in),
    .rd_idx_in   (idx),
    .rd_data_out ()
  );

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      conv_div_r <= stw_pkg::RST_CONV_DIV;
      prio_r     <= stw_pkg::RST_IRQ_PRIO;
      microsecond_divider_div_r <= stw_pkg::RST_MICROSECOND_DIVIDER_DIV;
      ms_lo_r    <= stw_pkg::RST_MS_DIV_LO;
      ms_hi_r    <= stw_pkg::RST_MS_DIV_HI;
      hms_div_r  <= stw_pkg::RST_HMS_DIV;
      wd_ctrl_r  <= stw_pkg::RST_ZERO;
      sec_load_r <= stw_pkg::RST_INTERVAL[6:0];
      ms_load_r  <= stw_pkg::RST_INTERVAL[6:0];
    end else if (wr_hit) begin
      unique case (sfr_addr_in)
        stw_pkg::ADDR_CONV_DIV:  conv_div_r <= sfr_wdata_in & stw_pkg::INTERVAL_MASK;
        stw_pkg::ADDR_IRQ_PRIO:  prio_r <= (sfr_wdata_in & stw_pkg::PRIO_MASK)
                                           | stw_pkg::PRIO_FIXED_ONES; // R16
        stw_pkg::ADDR_SEC_INT:   sec_load_r <= sfr_wdata_in[6:0];
        stw_pkg::ADDR_MS_INT:    ms_load_r <= sfr_wdata_in[6:0];
        stw_pkg::ADDR_MICROSECOND_DIVIDER_DIV:  microsecond_divider_div_r <= sfr_wdata_in & stw_pkg::MICROSECOND_DIVIDER_MASK;
        stw_pkg::ADDR_MS_DIV_LO: ms_lo_r <= sfr_wdata_in;
        stw_pkg::ADDR_MS_DIV_HI: ms_hi_r <= sfr_wdata_in;
        stw_pkg::ADDR_HMS_DIV:   hms_div_r <= sfr_wdata_in;
        stw_pkg::ADDR_WDOG_CTRL: wd_ctrl_r <= sfr_wdata_in;
        default: ;
      endcase
    end
  end

  assign conv_div = conv_div_r;
  assign microsecond_divider_div = microsecond_divider_div_r;
  assign ms_lo    = ms_lo_r;
  assign ms_hi    = ms_hi_r;
  assign hms_div  = hms_div_r;
  assign prio     = prio_r;
  assign wd_ctrl  = wd_ctrl_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sfr_rdata_out <= stw_pkg::RST_ZERO;
    end else if (ce_in) begin
      if (rd_hit) begin
        unique case (sfr_addr_in)
          stw_pkg::ADDR_SEC_INT: sfr_rdata_out <= {1'b0, sec_load_r}; // R5
          stw_pkg::ADDR_MS_INT:  sfr_rdata_out <= {1'b0, ms_load_r}; // R5
          stw_pkg::ADDR_IRQ_PRIO: sfr_rdata_out <= prio;
          default: sfr_rdata_out <= stw_pkg::RST_ZERO;
        endcase
      end else begin
        sfr_rdata_out <= stw_pkg::RST_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Write-one-then-zero sequence detection.

  logic rst_req_armed_r, wd_arm_armed_r, wd_dis_armed_r, wd_rst_armed_r;
  logic sw_reset_seq, wd_arm_seq, wd_dis_seq, wd_rst_seq;
  logic wr_software_reset_request, wr_wdog;
  assign wr_software_reset_request = wr_hit && (sfr_addr_in == stw_pkg::ADDR_SW_RESET);
  assign wr_wdog = wr_hit && (sfr_addr_in == stw_pkg::ADDR_WDOG_CTRL);
  assign sw_reset_seq = wr_software_reset_request && rst_req_armed_r && !sfr_wdata_in[stw_pkg::BIT_RESET_REQ]; // R2
  assign wd_arm_seq = wr_wdog && wd_arm_armed_r && !sfr_wdata_in[stw_pkg::BIT_WD_ARM]; // R12
  assign wd_dis_seq = wr_wdog && wd_dis_armed_r && !sfr_wdata_in[stw_pkg::BIT_WD_DISARM]; // R13
  assign wd_rst_seq = wr_wdog && wd_rst_armed_r && !sfr_wdata_in[stw_pkg::BIT_WD_RESTART]; // R14

  // Reads never touch the armed flags, so they cannot break a sequence.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rst_req_armed_r <= 1'b0;
      wd_arm_armed_r  <= 1'b0;
      wd_dis_armed_r  <= 1'b0;
      wd_rst_armed_r  <= 1'b0;
    end else begin
      if (wr_software_reset_request) begin
        rst_req_armed_r <= sfr_wdata_in[stw_pkg::BIT_RESET_REQ]; // R19
      end
      if (wr_wdog) begin
        wd_arm_armed_r <= sfr_wdata_in[stw_pkg::BIT_WD_ARM]; // R19
        wd_dis_armed_r <= sfr_wdata_in[stw_pkg::BIT_WD_DISARM]; // R19
        wd_rst_armed_r <= sfr_wdata_in[stw_pkg::BIT_WD_RESTART]; // R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Converter, modulator, data-rate and microsecond dividers.

  logic [6:0] conv_cnt_r;
  logic [stw_pkg::MOD_DIV_W-1:0] mod_cnt_r;
  logic [7:0] dec_cnt_r;
  logic [4:0] microsecond_divider_cnt_r;
  logic conv_wrap, mod_wrap, dec_wrap, microsecond_divider_wrap;
  // Wrapping at or above the limit stops a freshly lowered limit from costing a full roll-over.
  assign conv_wrap = (conv_cnt_r >= conv_div[6:0]); // R1
  assign mod_wrap  = conv_wrap && (&mod_cnt_r); // R1
  assign dec_wrap  = mod_wrap && (dec_cnt_r >= decimation_ratio_in - 8'h01); // R1
  assign microsecond_divider_wrap = (microsecond_divider_cnt_r >= microsecond_divider_div[4:0]); // R8

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      conv_cnt_r <= 7'h00;
      mod_cnt_r  <= '0;
      dec_cnt_r  <= 8'h00;
      conv_clk_tick_out  <= 1'b0;
      mod_clk_tick_out   <= 1'b0;
      data_rate_tick_out <= 1'b0;
    end else if (ce_in) begin
      conv_cnt_r <= conv_wrap ? 7'h00 : conv_cnt_r + 7'h01;
      if (conv_wrap) begin
        mod_cnt_r <= mod_cnt_r + {{(stw_pkg::MOD_DIV_W-1){1'b0}}, 1'b1};
      end
      if (mod_wrap) begin
        dec_cnt_r <= dec_wrap ? 8'h00 : dec_cnt_r + 8'h01;
      end
      conv_clk_tick_out  <= conv_wrap;
      mod_clk_tick_out   <= mod_wrap;
      data_rate_tick_out <= dec_wrap;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      microsecond_divider_cnt_r    <= 5'h00;
      microsecond_divider_tick_out <= 1'b0;
    end else if (ce_in) begin
      microsecond_divider_cnt_r    <= microsecond_divider_wrap ? 5'h00 : microsecond_divider_cnt_r + 5'h01;
      microsecond_divider_tick_out <= microsecond_divider_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Millisecond and hundred-millisecond ticks, stopped by the system timer power down.

  logic [15:0] ms_cnt_r;
  logic [7:0]  hms_cnt_r;
  logic        ms_wrap, hms_wrap, st_run;
  assign st_run   = ce_in && !system_timer_power_down_in; // R18
  assign ms_wrap  = (ms_cnt_r >= {ms_hi, ms_lo}); // R9
  assign hms_wrap = ms_wrap && (hms_cnt_r >= hms_div); // R11

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ms_cnt_r      <= 16'h0000;
      hms_cnt_r     <= 8'h00;
      msec_tick_out <= 1'b0;
      hms_tick_out  <= 1'b0;
    end else if (st_run) begin
      ms_cnt_r <= ms_wrap ? 16'h0000 : ms_cnt_r + 16'h0001; // R9
      if (ms_wrap) begin
        hms_cnt_r <= hms_wrap ? 8'h00 : hms_cnt_r + 8'h01; // R11
      end
      msec_tick_out <= ms_wrap; // R10
      hms_tick_out  <= hms_wrap;
    end else if (ce_in) begin
      msec_tick_out <= 1'b0;
      hms_tick_out  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Millisecond and seconds interval timers.

  logic [6:0] ms_int_cnt_r, sec_cnt_r;
  logic       ms_exp, sec_exp, ms_load_now, sec_load_now, ms_rd_clr, sec_rd_clr;
  assign ms_exp  = ms_wrap && st_run && (ms_int_cnt_r == 7'h00); // R6
  assign sec_exp = hms_wrap && st_run && (sec_cnt_r == 7'h00); // R3
  assign ms_load_now  = wr_hit && (sfr_addr_in == stw_pkg::ADDR_MS_INT)
                        && sfr_wdata_in[stw_pkg::BIT_LOAD_NOW]; // R5
  assign sec_load_now = wr_hit && (sfr_addr_in == stw_pkg::ADDR_SEC_INT)
                        && sfr_wdata_in[stw_pkg::BIT_LOAD_NOW]; // R5
  assign ms_rd_clr  = rd_hit && (sfr_addr_in == stw_pkg::ADDR_MS_INT);
  assign sec_rd_clr = rd_hit && (sfr_addr_in == stw_pkg::ADDR_SEC_INT);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ms_int_cnt_r <= stw_pkg::RST_INTERVAL[6:0];
      sec_cnt_r    <= stw_pkg::RST_INTERVAL[6:0];
    end else begin
      if (ms_load_now) begin
        ms_int_cnt_r <= sfr_wdata_in[6:0]; // R5
      end else if (ms_exp) begin
        ms_int_cnt_r <= ms_load_r; // R5
      end else if (ms_wrap && st_run) begin
        ms_int_cnt_r <= ms_int_cnt_r - 7'h01; // R6
      end
      if (sec_load_now) begin
        sec_cnt_r <= sfr_wdata_in[6:0]; // R5
      end else if (sec_exp) begin
        sec_cnt_r <= sec_load_r; // R5
      end else if (hms_wrap && st_run) begin
        sec_cnt_r <= sec_cnt_r - 7'h01; // R3
      end
    end
  end

  // A new expiry in the cycle of a clearing read keeps the flag set.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ms_irq_out  <= 1'b0;
      sec_irq_out <= 1'b0;
    end else begin
      if (ms_exp) begin
        ms_irq_out <= 1'b1; // R6
      end else if (ms_rd_clr) begin
        ms_irq_out <= 1'b0; // R7
      end
      if (sec_exp) begin
        sec_irq_out <= 1'b1; // R3
      end else if (sec_rd_clr) begin
        sec_irq_out <= 1'b0; // R4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Watchdog and reset requests.

  logic       wd_counting_r;
  logic [5:0] wd_cnt_r;
  logic       wd_run, wd_exp;
  assign wd_run = ce_in && !watchdog_power_down_in && wd_counting_r && hms_wrap
                  && !system_timer_power_down_in; // R18
  assign wd_exp = wd_run && (wd_cnt_r >= {1'b0, wd_ctrl[4:0]} + 6'h01); // R15

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wd_counting_r <= 1'b0;
    end else if (wd_arm_seq) begin
      wd_counting_r <= 1'b1; // R12
    end else if (wd_dis_seq) begin
      wd_counting_r <= 1'b0; // R13
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wd_cnt_r <= 6'h00;
    end else if (wd_rst_seq || wd_exp || !wd_counting_r) begin
      wd_cnt_r <= 6'h00; // R14
    end else if (wd_run) begin
      wd_cnt_r <= wd_cnt_r + 6'h01; // R15
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      watchdog_irq_out <= 1'b0;
      system_reset_out <= 1'b0;
    end else begin
      watchdog_irq_out <= wd_exp && watchdog_irq_enable_in; // R17 R20
      system_reset_out <= sw_reset_seq || (wd_exp && !watchdog_irq_enable_in); // R2 R20
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_priority_out <= stw_pkg::RST_IRQ_PRIO[4:0];
    end else begin
      irq_priority_out <= prio[4:0]; // R16
    end
  end
endmodule : stw_timers

// ===== test/stw_timers_checker.sv
// Concurrent checks on the ports of the system timers block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
module stw_timers_checker (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Register port and controls
  input wire logic       ce_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       watchdog_irq_enable_in,
  input wire logic       system_timer_power_down_in,
  // Ticks and events
  input wire logic       msec_tick_out,
  input wire logic       hms_tick_out,
  input wire logic       ms_irq_out,
  input wire logic       sec_irq_out,
  input wire logic       watchdog_irq_out,
  input wire logic       system_reset_out,
  input wire logic [4:0] irq_priority_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic software_reset_request_set_r;

  // Remembers the reset request bit from the last write to that register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      software_reset_request_set_r <= 1'b0;
    end else if (ce_in && sfr_wr_in && sfr_addr_in == stw_pkg::ADDR_SW_RESET) begin
      software_reset_request_set_r <= sfr_wdata_in[0];
    end
  end

  sequence s_software_reset_request_clear;
    software_reset_request_set_r && ce_in && sfr_wr_in && sfr_addr_in == 8'hF7 && !sfr_wdata_in[0];
  endsequence
  sequence s_prio_wr;
    ce_in && sfr_wr_in && sfr_addr_in == 8'hF8 ##1 !(sfr_wr_in && sfr_addr_in == 8'hF8);
  endsequence
  property p_software_reset_request;
    s_software_reset_request_clear |=> system_reset_out;
  endproperty
  a_software_reset_request: assert property (p_software_reset_request) else $error("reset request not honoured");
  property p_prio_wr;
    s_prio_wr |-> ##1 irq_priority_out == $past(sfr_wdata_in[4:0], 2);
  endproperty
  a_prio_wr: assert property (p_prio_wr) else $error("priority bits wrong");
  property p_prio_hi;
    ce_in && sfr_rd_in && sfr_addr_in == 8'hF8 |=> sfr_rdata_out[7:5] == 3'b111;
  endproperty
  a_prio_hi: assert property (p_prio_hi) else $error("priority top bits not one");
  property p_int_bit7;
    ce_in && sfr_rd_in && (sfr_addr_in == 8'hF9 || sfr_addr_in == 8'hFA) |=> !sfr_rdata_out[7];
  endproperty
  a_int_bit7: assert property (p_int_bit7) else $error("load bit read as one");
  property p_ms_clr;
    ce_in && sfr_rd_in && sfr_addr_in == 8'hFA ##1 !msec_tick_out |-> !ms_irq_out;
  endproperty
  a_ms_clr: assert property (p_ms_clr) else $error("ms flag not cleared");
  property p_sec_clr;
    ce_in && sfr_rd_in && sfr_addr_in == 8'hF9 ##1 !hms_tick_out |-> !sec_irq_out;
  endproperty
  a_sec_clr: assert property (p_sec_clr) else $error("seconds flag not cleared");
  property p_ms_rise;
    $rose(ms_irq_out) |-> msec_tick_out || $past(msec_tick_out) || $past(msec_tick_out, 2);
  endproperty
  a_ms_rise: assert property (p_ms_rise) else $error("ms flag without tick");
  property p_hms_src;
    hms_tick_out |-> msec_tick_out || $past(msec_tick_out) || $past(msec_tick_out, 2);
  endproperty
  a_hms_src: assert property (p_hms_src) else $error("100ms tick without 1ms tick");
  property p_pd_stop;
    system_timer_power_down_in [*3] |-> !msec_tick_out && !hms_tick_out && !watchdog_irq_out;
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("timer ran in power down");
  property p_wd_en;
    watchdog_irq_out |-> $past(watchdog_irq_enable_in);
  endproperty
  a_wd_en: assert property (p_wd_en) else $error("watchdog irq while disabled");
endmodule : stw_timers_checker

bind stw_timers stw_timers_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
  .watchdog_irq_enable_in(watchdog_irq_enable_in),
  .system_timer_power_down_in(system_timer_power_down_in), .msec_tick_out(msec_tick_out),
  .hms_tick_out(hms_tick_out), .ms_irq_out(ms_irq_out), .sec_irq_out(sec_irq_out),
  .watchdog_irq_out(watchdog_irq_out), .system_reset_out(system_reset_out),
  .irq_priority_out(irq_priority_out));

// ===== test/system_timers_watchdog_tb_top.sv
// Self-checking bench for the system timers block through its register port.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/100ps
module system_timers_watchdog_tb_top;
  logic       clk_in, rst_in, ce_in, sfr_wr_in, sfr_rd_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, decimation_ratio_in;
  logic       watchdog_irq_enable_in, watchdog_power_down_in, system_timer_power_down_in;
  logic [9:0] ev;
  logic [4:0] prio;
  int         n_mismatch, cmp_count, n;

  stw_timers uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .watchdog_irq_enable_in(watchdog_irq_enable_in),
    .watchdog_power_down_in(watchdog_power_down_in),
    .system_timer_power_down_in(system_timer_power_down_in),
    .decimation_ratio_in(decimation_ratio_in), .conv_clk_tick_out(ev[0]),
    .mod_clk_tick_out(ev[1]), .data_rate_tick_out(ev[2]), .microsecond_divider_tick_out(ev[3]),
    .msec_tick_out(ev[4]), .hms_tick_out(ev[5]), .ms_irq_out(ev[6]), .sec_irq_out(ev[7]),
    .watchdog_irq_out(ev[8]), .system_reset_out(ev[9]), .irq_priority_out(prio));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_wdata_in = v;
    sfr_wr_in = 1'b1;
    @(negedge clk_in);
    sfr_wr_in = 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge clk_in);
    sfr_rd_in = 1'b0;
    check(sfr_rdata_out, exp);
  endtask : rdc

  // Returns the cycles waited until the event is high; gives up once more than lim cycles have passed.
  task automatic wait_ev(input int s, input int lim, output int cnt);
    cnt = 0;
    while (ev[s] !== 1'b1) begin
      @(negedge clk_in);
      cnt++;
      if (cnt > lim) begin
        n_mismatch++;
        $display("[FAIL] %0t timeout on event %0d", $time, s);
        report_and_stop();
      end
    end
  endtask : wait_ev

  task automatic per(input int s, input int exp);
    int c;
    wait_ev(s, 2 * exp + 8, c);
    @(negedge clk_in);
    wait_ev(s, 2 * exp + 8, c);
    @(negedge clk_in);
    wait_ev(s, 2 * exp + 8, c);
    check(c + 1, exp);
  endtask : per

  task automatic quiet(input int s, input int cyc);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(negedge clk_in);
      if (ev[s] === 1'b1) hits++;
    end
    check(hits, 0);
  endtask : quiet

  initial begin
    {rst_in, ce_in, watchdog_irq_enable_in} = 3'b111;
    {sfr_wr_in, sfr_rd_in, watchdog_power_down_in, system_timer_power_down_in} = 4'h0;
    {sfr_addr_in, sfr_wdata_in} = 16'h0000;
    decimation_ratio_in = 8'h04;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    check(prio, 5'h00);
    rdc(8'hF8, 8'hE0);
    rdc(8'hF9, 8'h7F);
    rdc(8'hFA, 8'h7F);
    rdc(8'hF6, 8'h00);
    rdc(8'h10, 8'h00);
    per(3, 4);
    per(0, 4);
    per(1, 256);
    per(2, 1024);
    per(4, 4000);
    wr(8'hFB, 8'h04);
    per(3, 5);
    // Clock enable low must freeze the dividers, so no tick may appear.
    @(negedge clk_in);
    ce_in = 1'b0;
    quiet(3, 20);
    ce_in = 1'b1;
    wr(8'hF6, 8'h02);
    per(0, 3);
    per(2, 768);
    wr(8'hFC, 8'h09);
    wr(8'hFD, 8'h00);
    per(4, 10);
    wr(8'hFE, 8'h01);
    per(5, 20);
    wr(8'hF8, 8'h15);
    rdc(8'hF8, 8'hF5);
    check(prio, 5'h15);
    // Immediate load, then a delayed load that waits for the running count.
    wr(8'hFA, 8'h82);
    rdc(8'hFA, 8'h02);
    wait_ev(6, 40, n);
    rdc(8'hFA, 8'h02);
    check(ev[6], 1'b0);
    wr(8'hFA, 8'h09);
    wait_ev(6, 40, n);
    rdc(8'hFA, 8'h09);
    wait_ev(6, 120, n);
    check(n > 80, 1'b1);
    wr(8'hF9, 8'h81);
    rdc(8'hF9, 8'h01);
    wait_ev(7, 50, n);
    rdc(8'hF9, 8'h01);
    check(ev[7], 1'b0);
    wr(8'hF7, 8'h00);
    quiet(9, 5);
    wr(8'hF7, 8'h01);
    rdc(8'hF7, 8'h00);
    wr(8'hF7, 8'h00);
    wait_ev(9, 2, n);
    wr(8'hFF, 8'h80);
    wr(8'hFF, 8'h00);
    wait_ev(8, 50, n);
    check(n >= 12 && n <= 45, 1'b1);
    repeat (6) begin
      wr(8'hFF, 8'h21);
      wr(8'hFF, 8'h01);
      quiet(8, 10);
    end
    wait_ev(8, 70, n);
    check(n >= 25, 1'b1);
    @(negedge clk_in);
    watchdog_irq_enable_in = 1'b0;
    wait_ev(9, 70, n);
    watchdog_power_down_in = 1'b1;
    quiet(9, 100);
    watchdog_power_down_in = 1'b0;
    wr(8'hFF, 8'h40);
    wr(8'hFF, 8'h00);
    quiet(9, 100);
    system_timer_power_down_in = 1'b1;
    repeat (2) @(negedge clk_in);
    quiet(4, 50);
    system_timer_power_down_in = 1'b0;
    per(4, 10);
    report_and_stop();
  end
endmodule : system_timers_watchdog_tb_top
